// *** hdl/acs_pkg.sv ***
// package for the core calibration sequencer: register map, fields, timing
package acs_pkg;
  localparam logic [7:0]  ADDR_CFG      = 8'h00;
  localparam logic [7:0]  ADDR_TRIG     = 8'h04;
  localparam logic [7:0]  ADDR_STATUS   = 8'h08;
  localparam logic [7:0]  ADDR_IRQ_STS  = 8'h0C;
  localparam logic [7:0]  ADDR_IRQ_MASK = 8'h10;
  localparam logic [7:0]  ADDR_TRIM0    = 8'h20;
  localparam int          NUM_BANKS     = 6;
  localparam int          NUM_CORES     = 3;
  // cfg fields
  localparam int          CFG_TSEL_BIT  = 0;
  localparam int          CFG_BG_BIT    = 1;
  localparam int          CFG_FGOS_BIT  = 2;
  localparam int          CFG_BGOS_BIT  = 3;
  localparam int          CFG_SINGLE_BIT = 4;
  localparam int          CFG_INSEL_BIT = 5;
  localparam logic [31:0] CFG_RESET     = 32'h0000_0000;
  localparam logic [5:0]  CFG_MASK      = 6'h3F;
  // status fields
  localparam int          ST_FOREGROUND_COMPLETE_FLAG_BIT = 0;
  localparam int          ST_BUSY_BIT    = 1;
  // irq fields
  localparam int          IRQ_FOREGROUND_COMPLETE_FLAG_BIT = 0;
  localparam int          IRQ_SWAP_BIT    = 1;
  localparam int          IRQ_W           = 2;
  // factory trim default (arbitrary neutral value)
  localparam logic [15:0] TRIM_DEFAULT   = 16'h0080;
  localparam logic [11:0] MIDCODE        = 12'h000;
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;
  // timing
  localparam int          CLK_HZ         = 25_000_000;
  localparam int          FG_CAL_US      = 100;
  localparam int          FG_CAL_CYC     = FG_CAL_US * (CLK_HZ / 1_000_000);
  localparam int          BG_CAL_US      = 200;
  localparam int          BG_CAL_CYC     = BG_CAL_US * (CLK_HZ / 1_000_000);
  localparam logic [1:0]  CORE_A         = 2'd0;
  localparam logic [1:0]  CORE_B         = 2'd1;
  localparam logic [1:0]  CORE_C         = 2'd2;

  typedef enum logic [2:0] {
    ACS_IDLE = 3'b001,
    ACS_FG   = 3'b010,
    ACS_BG   = 3'b100
  } acs_state_t;

  typedef struct packed {
    logic [11:0] code_a;
    logic [11:0] code_b;
  } acs_sample_t;

  typedef struct packed {
    logic [1:0] core_for_a;
    logic [1:0] core_for_b;
    logic [1:0] core_cal;
  } acs_route_t;
endpackage

// *** hdl/acs_sequencer.sv ***
// calibration sequencer for three interleaved converter cores, axi4-lite regs
//
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
module acs_sequencer #(
  parameter int FG_CYCLES = acs_pkg::FG_CAL_CYC,
  parameter int BG_CYCLES = acs_pkg::BG_CAL_CYC
) (
  input  wire logic                 sys_clk,
  input  wire logic                 reset,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 calibration_trigger_pin,
  input  wire acs_pkg::acs_sample_t core_code [acs_pkg::NUM_CORES],
  output acs_pkg::acs_sample_t      sample_out_ff,
  output acs_pkg::acs_route_t       route_ff,
  output logic [acs_pkg::NUM_BANKS-1:0] bank_cal_ff,
  output logic [acs_pkg::NUM_BANKS-1:0] bank_phase_ff,
  output logic                      foreground_offset_correction,
  output logic                      background_offset_correction,
  output logic                      irq
);
  acs_pkg::acs_state_t state_ff;
  logic [31:0] cfg_ff;
  logic        software_calibration_trigger_ff;
  logic        trig_prev_ff;
  logic        foreground_complete_flag_ff;
  logic [acs_pkg::IRQ_W-1:0] irq_sts_ff;
  logic [acs_pkg::IRQ_W-1:0] irq_mask_ff;
  logic [15:0] trim_ff [acs_pkg::NUM_BANKS];
  logic [31:0] cnt_ff;
  logic        aw_hold_ff, w_hold_ff;
  logic [7:0]  awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic [1:0]  rot_ff;
  logic        boot_ff;

  logic trigger_source_select, background_calibration_enable;
  logic sel_trig, trig_rise, wr_fire, swap_evt, fg_end, wr_ok;
  logic [31:0] nxt_rdata;
  logic [1:0]  nxt_rresp;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  function automatic logic is_trim(input logic [7:0] a);
    is_trim = (a >= acs_pkg::ADDR_TRIM0) &&
              (a < acs_pkg::ADDR_TRIM0 + 8'(4 * acs_pkg::NUM_BANKS));
  endfunction

  assign trigger_source_select         = cfg_ff[acs_pkg::CFG_TSEL_BIT];
  assign background_calibration_enable = cfg_ff[acs_pkg::CFG_BG_BIT];
  assign foreground_offset_correction  =
    cfg_ff[acs_pkg::CFG_FGOS_BIT];
  assign background_offset_correction  =
    cfg_ff[acs_pkg::CFG_BGOS_BIT];

  // select pin or soft bit; soft bit is a level held by software
  assign sel_trig  = trigger_source_select ?
                     calibration_trigger_pin :
                     software_calibration_trigger_ff;
  assign trig_rise = sel_trig && !trig_prev_ff;

  // ---------------- axi4-lite write channel ----------------
  assign s_axi_awready = !aw_hold_ff && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_ff && !s_axi_bvalid;
  assign wr_fire       = aw_hold_ff && w_hold_ff && !s_axi_bvalid;
  assign wr_ok = (awaddr_ff == acs_pkg::ADDR_CFG) ||
                 (awaddr_ff == acs_pkg::ADDR_TRIG) ||
                 (awaddr_ff == acs_pkg::ADDR_STATUS) ||
                 (awaddr_ff == acs_pkg::ADDR_IRQ_STS) ||
                 (awaddr_ff == acs_pkg::ADDR_IRQ_MASK) ||
                 is_trim(awaddr_ff);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      aw_hold_ff   <= 1'b0;
      w_hold_ff    <= 1'b0;
      awaddr_ff    <= 8'h00;
      wdata_ff     <= 32'h0000_0000;
      wstrb_ff     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= acs_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_ff   <= 1'b0;
        w_hold_ff    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? acs_pkg::RESP_OKAY : acs_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // configuration and soft trigger
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cfg_ff                          <= acs_pkg::CFG_RESET;
      software_calibration_trigger_ff <= 1'b0;
      irq_mask_ff                     <= '0;
    end else if (wr_fire) begin
      unique case (awaddr_ff)
        acs_pkg::ADDR_CFG:
          cfg_ff <= merge(cfg_ff, wdata_ff, wstrb_ff) &
                    {26'h000_0000, acs_pkg::CFG_MASK};
        acs_pkg::ADDR_TRIG:
          if (wstrb_ff[0]) begin
            software_calibration_trigger_ff <= wdata_ff[0];
          end
        acs_pkg::ADDR_IRQ_MASK:
          if (wstrb_ff[0]) begin
            irq_mask_ff <= wdata_ff[acs_pkg::IRQ_W-1:0];
          end
        default: ;
      endcase
    end
  end

  // trims: factory defaults, host adjustable
  generate
    for (genvar g = 0; g < acs_pkg::NUM_BANKS; g++) begin : g_trim
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          trim_ff[g] <= acs_pkg::TRIM_DEFAULT;
        end else if (wr_fire &&
                     awaddr_ff == acs_pkg::ADDR_TRIM0 + 8'(4 * g)) begin
          trim_ff[g] <= 16'(merge({16'h0000, trim_ff[g]}, wdata_ff,
                                  wstrb_ff));
        end
      end
    end
  endgenerate

  // ---------------- axi4-lite read channel ----------------
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    nxt_rresp = acs_pkg::RESP_OKAY;
    nxt_rdata = 32'h0000_0000;
    if (is_trim(s_axi_araddr)) begin
      nxt_rdata = {16'h0000,
                   trim_ff[3'((s_axi_araddr - acs_pkg::ADDR_TRIM0) >> 2)]};
    end else begin
      unique case (s_axi_araddr)
        acs_pkg::ADDR_CFG:      nxt_rdata = cfg_ff;
        acs_pkg::ADDR_TRIG:
          nxt_rdata = {31'h0000_0000, software_calibration_trigger_ff};
        acs_pkg::ADDR_STATUS: begin
          nxt_rdata[acs_pkg::ST_FOREGROUND_COMPLETE_FLAG_BIT] = foreground_complete_flag_ff;
          nxt_rdata[acs_pkg::ST_BUSY_BIT]    = state_ff == acs_pkg::ACS_FG;
        end
        acs_pkg::ADDR_IRQ_STS:  nxt_rdata = {30'h0000_0000, irq_sts_ff};
        acs_pkg::ADDR_IRQ_MASK: nxt_rdata = {30'h0000_0000, irq_mask_ff};
        default:                nxt_rresp = acs_pkg::RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= acs_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= nxt_rdata;
      s_axi_rresp  <= nxt_rresp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------- calibration sequencer ----------------
  assign fg_end   = state_ff == acs_pkg::ACS_FG &&
                    cnt_ff == 32'(FG_CYCLES - 1);
  assign swap_evt = state_ff == acs_pkg::ACS_BG &&
                    cnt_ff == 32'(BG_CYCLES - 1);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_ff     <= acs_pkg::ACS_IDLE;
      cnt_ff       <= 32'h0000_0000;
      trig_prev_ff <= 1'b0;
      boot_ff      <= 1'b1;
    end else begin
      trig_prev_ff <= sel_trig;
      boot_ff      <= 1'b0;
      unique case (state_ff)
        acs_pkg::ACS_IDLE: begin
          cnt_ff <= 32'h0000_0000;
          if (boot_ff) begin
            state_ff <= acs_pkg::ACS_FG;
          end else if (background_calibration_enable) begin
            state_ff <= acs_pkg::ACS_BG;
          end else if (trig_rise) begin
            state_ff <= acs_pkg::ACS_FG;
          end
        end
        acs_pkg::ACS_FG: begin
          // edges seen here are ignored
          cnt_ff <= cnt_ff + 32'h0000_0001;
          if (fg_end) begin
            state_ff <= acs_pkg::ACS_IDLE;
          end
        end
        acs_pkg::ACS_BG: begin
          cnt_ff <= swap_evt ? 32'h0000_0000 : cnt_ff + 32'h0000_0001;
          if (!background_calibration_enable) begin
            state_ff <= acs_pkg::ACS_IDLE;
          end
        end
      endcase
    end
  end

  // background rotation: core being calibrated steps C -> A -> B -> C
  always_ff @(posedge sys_clk) begin
    if (reset || state_ff != acs_pkg::ACS_BG) begin
      rot_ff <= acs_pkg::CORE_C;
    end else if (swap_evt) begin
      rot_ff <= (rot_ff == acs_pkg::CORE_C) ? acs_pkg::CORE_A :
                (rot_ff == acs_pkg::CORE_A) ? acs_pkg::CORE_B :
                                              acs_pkg::CORE_C;
    end
  end

  // routing of cores to outputs
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      route_ff <= '{acs_pkg::CORE_A, acs_pkg::CORE_B, acs_pkg::CORE_C};
    end else if (state_ff == acs_pkg::ACS_BG) begin
      // spare takes over the slot of the core under calibration
      route_ff.core_cal   <= rot_ff;
      route_ff.core_for_a <= (rot_ff == acs_pkg::CORE_A) ?
                             acs_pkg::CORE_C : acs_pkg::CORE_A;
      route_ff.core_for_b <= (rot_ff == acs_pkg::CORE_B) ?
                             acs_pkg::CORE_C : acs_pkg::CORE_B;
    end else begin
      route_ff <= '{acs_pkg::CORE_A, acs_pkg::CORE_B, acs_pkg::CORE_C};
    end
  end

  // per-bank calibration state and alternating sample phase
  generate
    for (genvar b = 0; b < acs_pkg::NUM_BANKS; b++) begin : g_bank
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          bank_cal_ff[b]   <= 1'b0;
          bank_phase_ff[b] <= 1'(b % 2);
        end else begin
          bank_cal_ff[b] <= (state_ff == acs_pkg::ACS_FG && b / 2 != 2) ||
                            (state_ff == acs_pkg::ACS_BG &&
                             route_ff.core_cal == 2'(b / 2));
          bank_phase_ff[b] <= ~bank_phase_ff[b];
        end
      end
    end
  endgenerate

  // output samples
  always_ff @(posedge sys_clk) begin
    if (reset || state_ff == acs_pkg::ACS_FG) begin
      sample_out_ff <= '{acs_pkg::MIDCODE, acs_pkg::MIDCODE};
    end else if (cfg_ff[acs_pkg::CFG_SINGLE_BIT]) begin
      // both cores digitise the selected input, interleaved
      sample_out_ff.code_a <= cfg_ff[acs_pkg::CFG_INSEL_BIT] ?
                              core_code[route_ff.core_for_a].code_b :
                              core_code[route_ff.core_for_a].code_a;
      sample_out_ff.code_b <= cfg_ff[acs_pkg::CFG_INSEL_BIT] ?
                              core_code[route_ff.core_for_b].code_b :
                              core_code[route_ff.core_for_b].code_a;
    end else begin
      sample_out_ff.code_a <= core_code[route_ff.core_for_a].code_a;
      sample_out_ff.code_b <= core_code[route_ff.core_for_b].code_b;
    end
  end

  // done flag and interrupts; set wins over clear
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      foreground_complete_flag_ff <= 1'b0;
      irq_sts_ff                  <= '0;
    end else begin
      if (fg_end) begin
        foreground_complete_flag_ff <= 1'b1;
      end else if (trig_rise && state_ff == acs_pkg::ACS_IDLE) begin
        foreground_complete_flag_ff <= 1'b0;
      end
      irq_sts_ff <= (irq_sts_ff &
                     ~((wr_fire && awaddr_ff == acs_pkg::ADDR_IRQ_STS &&
                        wstrb_ff[0]) ? wdata_ff[acs_pkg::IRQ_W-1:0] : '0)) |
                    {swap_evt, fg_end};
    end
  end

  assign irq = |(irq_sts_ff & irq_mask_ff);

  // ---------------- assertions ----------------
  a_mid_code_fg: assert property (
    @(posedge sys_clk) disable iff (reset)
    $past(state_ff == acs_pkg::ACS_FG) |-> sample_out_ff == '0)
    else $error("output not midcode during foreground cal");
  a_boot_cal: assert property (
    @(posedge sys_clk)
    $fell(reset) |-> ##1 state_ff == acs_pkg::ACS_FG)
    else $error("no foreground cal after reset");
  a_trig_start: assert property (
    @(posedge sys_clk) disable iff (reset)
    state_ff == acs_pkg::ACS_IDLE && !boot_ff && !background_calibration_enable
    && trig_rise |=> state_ff == acs_pkg::ACS_FG)
    else $error("trigger edge did not start cal");
  a_bg_enter: assert property (
    @(posedge sys_clk) disable iff (reset)
    state_ff == acs_pkg::ACS_IDLE && !boot_ff && background_calibration_enable
    |=> state_ff == acs_pkg::ACS_BG)
    else $error("background enable not honoured");
  a_done_flag: assert property (
    @(posedge sys_clk) disable iff (reset)
    fg_end |=> foreground_complete_flag_ff && state_ff == acs_pkg::ACS_IDLE)
    else $error("done flag not set at end of cal");
  a_fg_stays: assert property (
    @(posedge sys_clk) disable iff (reset)
    state_ff == acs_pkg::ACS_FG && !fg_end |=> state_ff == acs_pkg::ACS_FG)
    else $error("foreground cal cut short");
  a_rotate_order: assert property (
    @(posedge sys_clk) disable iff (reset)
    swap_evt && rot_ff == acs_pkg::CORE_C && background_calibration_enable
    |=> rot_ff == acs_pkg::CORE_A)
    else $error("rotation order broken");
  a_spare_sub: assert property (
    @(posedge sys_clk) disable iff (reset)
    state_ff == acs_pkg::ACS_BG && rot_ff == acs_pkg::CORE_A
    |=> route_ff.core_for_a == acs_pkg::CORE_C)
    else $error("spare not substituted for core a");
  a_irq_fg_set: assert property (
    @(posedge sys_clk) disable iff (reset)
    $rose(irq_sts_ff[acs_pkg::IRQ_FOREGROUND_COMPLETE_FLAG_BIT]) |-> $past(fg_end))
    else $error("done interrupt set without end of cal");

  c_boot_done: cover property (@(posedge sys_clk) fg_end);
  c_bg_swap:   cover property (@(posedge sys_clk) swap_evt);
  c_irq:       cover property (@(posedge sys_clk) irq);
endmodule

// *** sim/acs_sequencer_tb_top.sv ***
// self-checking bench for the core calibration sequencer
`timescale 1ns/1ns
module acs_sequencer_tb_top;
  localparam int FGC = 20;
  localparam int BGC = 30;
  logic                 sys_clk = 1'b0;
  logic                 reset   = 1'b1;
  logic [7:0]           awaddr  = 8'h00;
  logic [7:0]           araddr  = 8'h00;
  logic                 awvalid = 1'b0;
  logic                 wvalid  = 1'b0;
  logic                 bready  = 1'b0;
  logic                 arvalid = 1'b0;
  logic                 rready  = 1'b0;
  logic                 pin     = 1'b0;
  logic [31:0]          wdata   = 32'h0000_0000;
  logic                 awready, wready, bvalid, arready, rvalid;
  logic [1:0]           bresp, rresp, rsp;
  logic [31:0]          rdata, rd;
  acs_pkg::acs_sample_t code [acs_pkg::NUM_CORES];
  acs_pkg::acs_sample_t smp;
  acs_pkg::acs_route_t  rt;
  logic [5:0]           bcal, bph, pb;
  logic                 fgos, bgos, irq;
  int                   n_mismatch = 0;
  int                   cmp_count = 0;

  acs_sequencer #(.FG_CYCLES(FGC), .BG_CYCLES(BGC)) acs_sequencer_i (
    .sys_clk(sys_clk), .reset(reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .calibration_trigger_pin(pin), .core_code(code), .sample_out_ff(smp),
    .route_ff(rt), .bank_cal_ff(bcal), .bank_phase_ff(bph),
    .foreground_offset_correction(fgos),
    .background_offset_correction(bgos), .irq(irq));

  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic give_up();
    n_mismatch++;
    $display("CHECK FAILED wait bound expected done seen timeout");
    summarize();
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    @(posedge sys_clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(negedge sys_clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      r  = bresp;
      @(posedge sys_clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) begin
        bready <= 1'b0;
        return;
      end
    end
    give_up();
  endtask

  task automatic rdr(logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    logic ta, tr;
    @(posedge sys_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(negedge sys_clk);
      ta = arvalid & arready;
      tr = rvalid;
      d  = rdata;
      r  = rresp;
      @(posedge sys_clk);
      if (ta) arvalid <= 1'b0;
      if (tr) begin
        rready <= 1'b0;
        return;
      end
    end
    give_up();
  endtask

  task automatic wrc(logic [7:0] a, logic [31:0] d);
    wr(a, d, rsp);
    check("write resp", rsp, acs_pkg::RESP_OKAY);
  endtask

  task automatic rdc(string nm, logic [7:0] a, logic [31:0] exp);
    rdr(a, rd, rsp);
    check(nm, rd, exp);
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 40; i++) begin
      rdr(acs_pkg::ADDR_STATUS, rd, rsp);
      if (rd[acs_pkg::ST_BUSY_BIT] === 1'b0) return;
    end
    give_up();
  endtask

  task automatic set_codes();
    @(posedge sys_clk);
    for (int k = 0; k < acs_pkg::NUM_CORES; k++) begin
      code[k] <= {12'($urandom) | 12'h001, 12'($urandom) | 12'h001};
    end
  endtask

  task automatic pulse_pin();
    @(posedge sys_clk);
    pin <= 1'b1;
    repeat (2) @(posedge sys_clk);
    pin <= 1'b0;
  endtask

  // expected output pair from routing and channel mode
  function automatic acs_pkg::acs_sample_t model(logic [5:0] c,
                                                 logic [1:0] fa,
                                                 logic [1:0] fb);
    model.code_a = (c[4] & c[5]) ? code[fa].code_b : code[fa].code_a;
    model.code_b = (c[4] & ~c[5]) ? code[fb].code_a : code[fb].code_b;
  endfunction

  initial begin
    logic [5:0]  cfgs [3];
    logic [1:0]  prev, ecal, fa, fb;
    logic [15:0] t;
    int          i, errs;
    for (int k = 0; k < acs_pkg::NUM_CORES; k++) code[k] = '0;
    cfgs = '{6'h00, 6'h10, 6'h30};
    void'($urandom(32'hb81a2737));
    set_codes();
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    check("reset route", rt, 6'b00_01_10);
    @(posedge sys_clk);
    reset <= 1'b0;
    repeat (4) @(negedge sys_clk);
    check("power-up midcode", smp, 24'h000_000);
    repeat (FGC + 3) @(posedge sys_clk);
    rdc("foreground_complete_flag", acs_pkg::ADDR_STATUS, 32'h0000_0001);
    rdc("irq sts", acs_pkg::ADDR_IRQ_STS, 32'h0000_0001);
    wrc(acs_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
    check("irq masked", irq, 1'b0);
    wrc(acs_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
    check("irq raised", irq, 1'b1);
    wrc(acs_pkg::ADDR_IRQ_STS, 32'h0000_0001);
    rdc("irq cleared", acs_pkg::ADDR_IRQ_STS, 32'h0000_0000);
    check("irq low", irq, 1'b0);
    for (int k = 0; k < acs_pkg::NUM_BANKS; k++) begin
      t = 16'($urandom);
      rdc("trim reset", acs_pkg::ADDR_TRIM0 + 8'(4 * k),
          32'(acs_pkg::TRIM_DEFAULT));
      wrc(acs_pkg::ADDR_TRIM0 + 8'(4 * k), {16'h0000, t});
      rdc("trim rw", acs_pkg::ADDR_TRIM0 + 8'(4 * k), {16'h0000, t});
    end
    rdr(8'hF0, rd, rsp);
    check("unmapped read", rsp, acs_pkg::RESP_SLVERR);
    wr(8'hF0, 32'hFFFF_FFFF, rsp);
    check("unmapped write", rsp, acs_pkg::RESP_SLVERR);
    wrc(acs_pkg::ADDR_CFG, 32'h0000_00C4);
    rdc("cfg readback", acs_pkg::ADDR_CFG, 32'h0000_0004);
    check("fg offset", {fgos, bgos}, 2'b10);
    wrc(acs_pkg::ADDR_CFG, 32'h0000_0008);
    check("bg offset", {fgos, bgos}, 2'b01);
    $display("test registers done");

    for (int k = 0; k < 3; k++) begin
      set_codes();
      wrc(acs_pkg::ADDR_CFG, 32'(cfgs[k]));
      repeat (3) @(negedge sys_clk);
      check("routing", smp, model(cfgs[k], acs_pkg::CORE_A,
                                  acs_pkg::CORE_B));
    end
    $display("test routing done");

    wrc(acs_pkg::ADDR_CFG, 32'h0000_0000);
    wrc(acs_pkg::ADDR_TRIG, 32'h0000_0000);
    wrc(acs_pkg::ADDR_TRIG, 32'h0000_0001);
    rdc("soft trigger", acs_pkg::ADDR_STATUS, 32'h0000_0002);
    check("fg midcode", smp, 24'h000_000);
    check("fg banks", bcal, 6'b00_1111);
    wrc(acs_pkg::ADDR_TRIG, 32'h0000_0000);
    wrc(acs_pkg::ADDR_TRIG, 32'h0000_0001);
    // first cal ends here; a restarted one would still be busy
    repeat (12) @(posedge sys_clk);
    rdc("retrigger ignored", acs_pkg::ADDR_STATUS, 32'h0000_0001);
    pulse_pin();
    repeat (3) @(posedge sys_clk);
    rdc("pin not selected", acs_pkg::ADDR_STATUS, 32'h0000_0001);
    wrc(acs_pkg::ADDR_CFG, 32'h0000_0001);
    pulse_pin();
    rdc("pin trigger", acs_pkg::ADDR_STATUS, 32'h0000_0002);
    wait_idle();
    $display("test triggers done");

    set_codes();
    wrc(acs_pkg::ADDR_IRQ_MASK, 32'h0000_0002);
    wrc(acs_pkg::ADDR_CFG, 32'h0000_0002);
    wrc(acs_pkg::ADDR_TRIG, 32'h0000_0001);
    ecal = acs_pkg::CORE_C;
    errs = 0;
    @(negedge sys_clk);
    pb = bph;
    for (int s = 0; s < 6; s++) begin
      prev = rt.core_cal;
      for (i = 0; i < BGC + 10 && rt.core_cal === prev; i++) begin
        @(negedge sys_clk);
        if (smp.code_a === 12'h000 || smp.code_b === 12'h000) errs++;
        if (bph !== ~pb || bph[0] === bph[1] || bph[2] === bph[3]) errs++;
        pb = bph;
      end
      if (rt.core_cal === prev) give_up();
      ecal = (ecal == acs_pkg::CORE_C) ? acs_pkg::CORE_A : ecal + 2'd1;
      fa = (ecal == acs_pkg::CORE_A) ? acs_pkg::CORE_C : acs_pkg::CORE_A;
      fb = (ecal == acs_pkg::CORE_B) ? acs_pkg::CORE_C : acs_pkg::CORE_B;
      check("cal core", rt.core_cal, ecal);
      check("spare route", {rt.core_for_a, rt.core_for_b}, {fa, fb});
      repeat (3) @(negedge sys_clk);
      pb = bph;
      check("bank cal", bcal, 6'b00_0011 << (2 * ecal));
      check("bg sample", smp, model(6'h02, fa, fb));
    end
    check("flow and phase", errs, 0);
    check("swap irq", irq, 1'b1);
    wrc(acs_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
    check("swap irq masked", irq, 1'b0);
    $display("test background done");
    summarize();
  end
endmodule
